// ==== logic/sssc_pkg.sv ====
// constants, types and functional notes for the soft-start and sync block
package sssc_pkg;
    localparam int unsigned CLK_HZ     = 100_000_000;
    localparam int unsigned MS_PER_S   = 1000;
    // time units
    localparam int unsigned STEP_MS    = 10;
    localparam int unsigned INIT_MS    = 6;
    localparam int unsigned CHECK_MS   = 15;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned TICK_CYC   = CYC_PER_MS;
    // strap level codes
    localparam logic [1:0] LVL_LOW     = 2'h0;
    localparam logic [1:0] LVL_OPEN    = 2'h1;
    localparam logic [1:0] LVL_HIGH    = 2'h2;
    localparam logic [1:0] LVL_RES     = 2'h3;
    // delay / ramp times in ms
    localparam logic [7:0] T_LOW_MS    = 8'h0a;
    localparam logic [7:0] T_OPEN_MS   = 8'h32;
    localparam logic [7:0] T_HIGH_MS   = 8'h64;
    localparam logic [4:0] RES_MAX     = 5'h14;
    // oscillator divide ratio from 8 MHz
    localparam logic [5:0] N_MIN       = 6'h04;
    localparam logic [5:0] N_MAX       = 6'h28;
    localparam logic [5:0] N_200K      = 6'h28;
    localparam logic [5:0] N_400K      = 6'h14;
    localparam logic [5:0] N_1M        = 6'h08;
    localparam logic [3:0] OSC_PRE     = 4'h6; // 100 MHz / 6 ~ 16 MHz
    localparam logic [15:0] DET_WIN    = 16'h0fa0; // 40 us detect window
    localparam logic [3:0] DET_EDGES   = 4'h4;
    // register map (apb byte addresses)
    localparam logic [7:0] A_CTRL      = 8'h00;
    localparam logic [7:0] A_DELAY     = 8'h04;
    localparam logic [7:0] A_RAMP      = 8'h08;
    localparam logic [7:0] A_FREQ      = 8'h0c;
    localparam logic [7:0] A_STATUS    = 8'h10;
    localparam logic [7:0] A_VTGT      = 8'h14;
    localparam logic [15:0] VTGT_RST   = 16'h0258;
    typedef enum logic [1:0] {SSSC_IN, SSSC_AUTO, SSSC_OUT} sssc_role_type;
endpackage

// ==== logic/sssc_strap_if.sv ====
// strap values handed from the strap decoder to the sequencer
`timescale 1ns/10ps
interface sssc_strap_if;
    logic       load;
    logic [7:0] delay_ms;
    logic [7:0] ramp_ms;
    logic [1:0] role;
    logic [5:0] div_n;
    modport src (output load, delay_ms, ramp_ms, role, div_n);
    modport dst (input  load, delay_ms, ramp_ms, role, div_n);
endinterface

// ==== logic/sssc_strap_dec.sv ====
// decodes sampled strap levels and resistor codes into settings
`timescale 1ns/10ps
module sssc_strap_dec
    import sssc_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // sample request and raw straps
    input  wire logic       sample,
    input  wire logic [1:0] dly_lvl,
    input  wire logic [4:0] dly_code,
    input  wire logic [1:0] ramp_lvl,
    input  wire logic [4:0] ramp_code,
    input  wire logic [1:0] cfg_lvl,
    input  wire logic [1:0] clk_lvl,
    input  wire logic [4:0] clk_code,
    input  wire logic       first,
    // decoded result
    sssc_strap_if.src       st
);
    function automatic logic [7:0] to_ms(logic [1:0] l, logic [4:0] c);
        logic [4:0] cc;
        cc = (c > RES_MAX) ? RES_MAX : c;
        unique case (l)
            LVL_LOW:  to_ms = T_LOW_MS;
            LVL_OPEN: to_ms = T_OPEN_MS;
            LVL_HIGH: to_ms = T_HIGH_MS;
            default:  to_ms = 8'(cc * STEP_MS);
        endcase
    endfunction
    // tabulated divide ratios for the 21 resistor steps
    function automatic logic [5:0] res_n(logic [4:0] c);
        logic [5:0] t [0:20];
        t = '{6'h28,6'h24,6'h21,6'h1e,6'h1b,6'h19,6'h16,6'h14,6'h13,
              6'h11,6'h0f,6'h0e,6'h0d,6'h0c,6'h0b,6'h09,6'h08,6'h07,
              6'h06,6'h05,6'h04};
        res_n = (c > RES_MAX) ? t[20] : t[c];
    endfunction
    // latch decoded settings only when asked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st.load     <= 1'b0;
            st.delay_ms <= 8'h00;
            st.ramp_ms  <= 8'h00;
            st.role     <= 2'h0;
            st.div_n    <= N_400K;
        end else begin
            st.load <= sample;
            if (sample) begin
                st.delay_ms <= to_ms(dly_lvl, dly_code);
                st.ramp_ms  <= to_ms(ramp_lvl, ramp_code);
                if (first) begin
                    st.role <= (cfg_lvl == LVL_LOW) ? 2'(SSSC_IN) :
                               (cfg_lvl == LVL_HIGH) ? 2'(SSSC_OUT) :
                               2'(SSSC_AUTO);
                    unique case (clk_lvl)
                        LVL_LOW:  st.div_n <= N_200K;
                        LVL_OPEN: st.div_n <= N_400K;
                        LVL_HIGH: st.div_n <= N_1M;
                        default:  st.div_n <= res_n(clk_code);
                    endcase
                    if (cfg_lvl == LVL_HIGH)
                        st.div_n <= N_400K;
                end
            end
        end
    end
endmodule // sssc_strap_dec

// ==== logic/sssc_top.sv ====
// soft-start sequencer, sync pin role and apb register file
`timescale 1ns/10ps
module sssc_top
    import sssc_pkg::*;
#(
    parameter int unsigned CHECK_CYC = CHECK_MS * CYC_PER_MS,
    parameter int unsigned MS_CYC    = TICK_CYC
)(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // turn-on request and straps
    input  wire logic        turn_on,
    input  wire logic [1:0]  delay_strap,
    input  wire logic [4:0]  delay_select_resistor,
    input  wire logic [1:0]  ramp_strap,
    input  wire logic [4:0]  ramp_select_resistor,
    input  wire logic [1:0]  cfg_strap,
    input  wire logic [1:0]  sync_strap,
    input  wire logic [4:0]  sync_select_resistor,
    // shared clock pin
    input  wire logic        sync_in,
    output logic             sync_out,
    output logic             sync_oe,
    // outputs to the power stage
    output logic             ready,
    output logic [15:0]      vref,
    output logic             ramp_done,
    output logic             pll_ext_ref,
    output logic             pll_clk
);
    typedef enum logic [2:0] {
        S_CHECK, S_LOAD, S_READY, S_DETECT, S_DELAY, S_RAMP, S_ON
    } sssc_state_type;

    sssc_state_type state;
    sssc_strap_if   st ();
    logic [31:0] chk_cnt;
    logic        first;
    logic        sample;
    logic        restore;
    logic [2:0]  on_s, syn_s;
    logic        on_lvl, on_prev, syn_prev;
    logic [31:0] ms_cnt;
    logic [8:0]  ms_left;
    logic [7:0]  delay_ms, ramp_ms;
    logic        bus_dly, bus_ramp;
    logic [7:0]  bus_dly_ms, bus_ramp_ms;
    logic [5:0]  div_n, bus_n;
    logic        bus_n_set;
    logic [15:0] vtgt, step, next_vref;
    logic [15:0] det_cnt;
    logic [3:0]  edges;
    logic        ext_ok;
    logic [3:0]  pre_cnt;
    logic [5:0]  osc_cnt;
    logic        osc_tick;
    logic        apb_wr, apb_rd, hit;

    sssc_strap_dec u_dec (
        .pclk      (pclk),
        .presetn   (presetn),
        .sample    (sample),
        .dly_lvl   (delay_strap),
        .dly_code  (delay_select_resistor),
        .ramp_lvl  (ramp_strap),
        .ramp_code (ramp_select_resistor),
        .cfg_lvl   (cfg_strap),
        .clk_lvl   (sync_strap),
        .clk_code  (sync_select_resistor),
        .first     (first),
        .st        (st)
    );

    // three-stage sync; act when stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_s  <= 3'h0;
            syn_s <= 3'h0;
        end else begin
            on_s  <= {on_s[1:0], turn_on};
            syn_s <= {syn_s[1:0], sync_in};
        end
    end
    assign on_lvl = (on_s[2] == on_s[1]) ? on_s[1] : on_prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_prev  <= 1'b0;
            syn_prev <= 1'b0;
        end else begin
            on_prev <= on_lvl;
            if (syn_s[2] == syn_s[1])
                syn_prev <= syn_s[1];
        end
    end

    // effective settings: bus values win over straps
    assign delay_ms = bus_dly ? bus_dly_ms : st.delay_ms;
    assign ramp_ms  = bus_ramp ? bus_ramp_ms : st.ramp_ms;
    assign div_n    = bus_n_set ? bus_n : st.div_n;
    assign sample   = (state == S_LOAD);

    // apb decode; writes ignored while checking memory
    assign hit    = (paddr[7:0] <= A_VTGT) && (paddr[1:0] == 2'h0)
                    && (paddr[31:8] == 24'h0);
    assign apb_wr = psel && penable && pwrite && pready && hit
                    && (state != S_CHECK);
    assign apb_rd = psel && !penable && !pwrite;

    // ramp step so the reference lands on target at ramp end
    assign step = (ramp_ms == 8'h00) ? vtgt :
                  16'(vtgt / {8'h00, ramp_ms});
    assign next_vref = (ms_left <= 9'h001) ? vtgt :
                       (({1'b0, vref} + {1'b0, step} > {1'b0, vtgt}) ? vtgt :
                        16'(vref + step));

    // start-up, turn-on and ramp sequencing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= S_CHECK;
            chk_cnt   <= 32'h0;
            first     <= 1'b1;
            ready     <= 1'b0;
            ms_cnt    <= 32'h0;
            ms_left   <= 9'h000;
            vref      <= 16'h0000;
            ramp_done <= 1'b0;
            det_cnt   <= 16'h0000;
            edges     <= 4'h0;
            ext_ok    <= 1'b0;
        end else begin
            ms_cnt <= (ms_cnt >= MS_CYC - 1) ? 32'h0 : ms_cnt + 32'h1;
            unique case (state)
                S_CHECK: begin
                    ready   <= 1'b0;
                    chk_cnt <= chk_cnt + 32'h1;
                    if (chk_cnt >= CHECK_CYC - 1)
                        state <= S_LOAD;
                end
                S_LOAD: begin
                    first <= 1'b0;
                    ready <= 1'b1;
                    state <= S_READY;
                end
                S_READY: begin
                    vref      <= 16'h0000;
                    ramp_done <= 1'b0;
                    if (on_lvl && !on_prev) begin
                        det_cnt <= 16'h0000;
                        edges   <= 4'h0;
                        ms_cnt  <= 32'h0;
                        // 6 ms floor plus strap delay
                        ms_left <= 9'(INIT_MS) + {1'b0, delay_ms};
                        state   <= S_DETECT;
                    end
                end
                S_DETECT: begin
                    det_cnt <= det_cnt + 16'h1;
                    if (syn_s[2] == syn_s[1] && syn_s[1] && !syn_prev
                        && edges != 4'hf)
                        edges <= edges + 4'h1;
                    if (st.role == 2'(SSSC_OUT)) begin
                        ext_ok <= 1'b0;
                        state  <= S_DELAY;
                    end else if (det_cnt >= DET_WIN) begin
                        ext_ok <= (edges >= DET_EDGES);
                        state  <= S_DELAY;
                    end
                    if (ms_cnt >= MS_CYC - 1 && ms_left != 9'h0)
                        ms_left <= ms_left - 9'h1;
                end
                S_DELAY: begin
                    if (ms_cnt >= MS_CYC - 1)
                        ms_left <= ms_left - 9'h1;
                    if (ms_left == 9'h0 || (ms_left == 9'h1
                        && ms_cnt >= MS_CYC - 1)) begin
                        ms_left <= {1'b0, ramp_ms};
                        state   <= S_RAMP;
                    end
                end
                S_RAMP: begin
                    if (ramp_ms == 8'h00 || ms_left == 9'h0) begin
                        vref  <= vtgt;
                        state <= S_ON;
                    end else if (ms_cnt >= MS_CYC - 1) begin
                        vref    <= next_vref;
                        ms_left <= ms_left - 9'h1;
                    end
                end
                S_ON: begin
                    ramp_done <= 1'b1;
                    if (!on_lvl)
                        state <= S_READY;
                end
                default: state <= S_CHECK;
            endcase
            if (restore) begin
                state   <= S_CHECK;
                chk_cnt <= 32'h0;
                ready   <= 1'b0;
            end
        end
    end

    // oscillator: ~16 MHz prescale, divide by n, one toggle per tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt  <= 4'h0;
            osc_cnt  <= 6'h00;
            osc_tick <= 1'b0;
        end else begin
            osc_tick <= 1'b0;
            pre_cnt  <= (pre_cnt == OSC_PRE - 4'h1) ? 4'h0 : pre_cnt + 4'h1;
            if (pre_cnt == 4'h0) begin
                if (osc_cnt >= div_n - 6'h1) begin
                    osc_cnt  <= 6'h00;
                    osc_tick <= 1'b1;
                end else begin
                    osc_cnt <= osc_cnt + 6'h1;
                end
            end
        end
    end

    // pll reference select and clock pin drive
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_clk     <= 1'b0;
            pll_ext_ref <= 1'b0;
            sync_out    <= 1'b0;
            sync_oe     <= 1'b0;
        end else begin
            pll_ext_ref <= ext_ok && (st.role != 2'(SSSC_OUT));
            sync_oe     <= (st.role == 2'(SSSC_OUT)) && !first;
            if (ext_ok && st.role != 2'(SSSC_OUT))
                pll_clk <= syn_prev;
            else if (osc_tick)
                pll_clk <= !pll_clk;
            if (osc_tick)
                sync_out <= !sync_out;
        end
    end

    // register writes; restore is a self-clearing control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_dly     <= 1'b0;
            bus_ramp    <= 1'b0;
            bus_n_set   <= 1'b0;
            bus_dly_ms  <= 8'h00;
            bus_ramp_ms <= 8'h00;
            bus_n       <= N_400K;
            vtgt        <= VTGT_RST;
            restore     <= 1'b0;
        end else begin
            restore <= 1'b0;
            if (apb_wr) begin
                unique case (paddr[7:0])
                    A_CTRL:  restore <= pwdata[0];
                    A_DELAY: begin
                        bus_dly    <= 1'b1;
                        bus_dly_ms <= pwdata[7:0];
                    end
                    A_RAMP: begin
                        bus_ramp    <= 1'b1;
                        bus_ramp_ms <= pwdata[7:0];
                    end
                    A_FREQ: begin
                        bus_n_set <= 1'b1;
                        bus_n <= (pwdata[5:0] < N_MIN) ? N_MIN :
                                 (pwdata[5:0] > N_MAX || pwdata[31:6] != 0)
                                 ? N_MAX : pwdata[5:0];
                    end
                    A_VTGT:  vtgt <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // read data registered in setup, answer in access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && (!hit || state == S_CHECK);
            if (apb_rd) begin
                unique case (paddr[7:0])
                    A_DELAY:  prdata <= {24'h0, delay_ms};
                    A_RAMP:   prdata <= {24'h0, ramp_ms};
                    A_FREQ:   prdata <= {26'h0, div_n};
                    A_STATUS: prdata <= {24'h0, ext_ok, st.role,
                                         ramp_done, 1'b0, 3'(state)};
                    A_VTGT:   prdata <= {16'h0, vtgt};
                    default:  prdata <= 32'h0;
                endcase
            end
        end
    end
endmodule // sssc_top

// ==== test/sssc_top_sva.sv ====
// concurrent checks on the ports of the soft-start and sync block
`timescale 1ns/10ps
module sssc_top_sva
    import sssc_pkg::*;
#(
    parameter int unsigned CHECK_CYC = 50,
    parameter int unsigned MS_CYC    = 20
)(
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    // sequencer and clock pin
    input wire logic        turn_on,
    input wire logic        ready,
    input wire logic [15:0] vref,
    input wire logic        ramp_done,
    input wire logic        sync_oe,
    input wire logic        pll_ext_ref
);
    localparam int unsigned INIT_CYC = INIT_MS * MS_CYC;
    logic [15:0] up_cnt; // cycles since reset release
    logic [15:0] on_cnt; // cycles with turn_on held high
    // saturating count from reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) up_cnt <= 16'h0;
        else if (up_cnt != 16'hffff) up_cnt <= up_cnt + 16'h1;
    end
    // saturating count of turn_on high time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) on_cnt <= 16'h0;
        else if (!turn_on) on_cnt <= 16'h0;
        else if (on_cnt != 16'hffff) on_cnt <= on_cnt + 16'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access; psel && penable; endsequence
    sequence s_busy; !ready && !$past(ready); endsequence
    property p_zero_wait; s_access |-> pready; endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("pready missing in access cycle");
    property p_busy_refuse; s_access and s_busy |-> pslverr; endproperty
    a_busy_refuse: assert property (p_busy_refuse)
        else $error("access during memory check not refused");
    property p_ready_late; ready |-> up_cnt >= CHECK_CYC; endproperty
    a_ready_late: assert property (p_ready_late)
        else $error("ready before memory check ended");
    property p_ready_due; up_cnt == CHECK_CYC + 6 |-> ready; endproperty
    a_ready_due: assert property (p_ready_due)
        else $error("ready missing after strap load");
    property p_mono; on_cnt > 4 |-> vref >= $past(vref); endproperty
    a_mono: assert property (p_mono)
        else $error("reference fell during ramp");
    property p_done_hold; ramp_done && on_cnt > 4 |=> ramp_done; endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("ramp done dropped while on");
    property p_done_tgt; $rose(ramp_done) |-> vref == VTGT_RST; endproperty
    a_done_tgt: assert property (p_done_tgt)
        else $error("ramp ended off target");
    property p_no_early;
        on_cnt != 0 && on_cnt < INIT_CYC && $past(vref) == 16'h0
            |-> vref == 16'h0;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("ramp began before pre-ramp wait");
    property p_oe_keep;
        ready && $past(ready, 4) |-> $stable(sync_oe);
    endproperty
    a_oe_keep: assert property (p_oe_keep)
        else $error("clock pin role changed");
    property p_oe_int; sync_oe |-> !pll_ext_ref; endproperty
    a_oe_int: assert property (p_oe_int)
        else $error("output role followed the pin");
endmodule // sssc_top_sva

bind sssc_top sssc_top_sva #(.CHECK_CYC(CHECK_CYC), .MS_CYC(MS_CYC)) i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .turn_on(turn_on),
    .ready(ready), .vref(vref), .ramp_done(ramp_done), .sync_oe(sync_oe),
    .pll_ext_ref(pll_ext_ref));

// ==== test/sssc_clk_src.sv ====
// clock source model standing on the shared clock pin
`timescale 1ns/10ps
module sssc_clk_src #(
    parameter int HALF_NS = 40
)(
    // enable and pin
    input wire logic run,
    output logic     clk_out
);
    // toggles only while enabled, pin rests low otherwise
    initial begin
        clk_out = 1'b0;
        #13;
        forever begin
            #(HALF_NS);
            clk_out = run ? ~clk_out : 1'b0;
        end
    end
endmodule // sssc_clk_src

// ==== test/sssc_top_bench.sv ====
// self-checking bench for the soft-start and sync block
`timescale 1ns/10ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %0t got %0h want %0h", $time, (a), (e)); end end
module sssc_top_bench
    import sssc_pkg::*;
();
    localparam int CK = 50;
    localparam int MS = 20;
    localparam int INIT = INIT_MS;
    logic        pclk = 1'b0, presetn = 1'b0, turn_on = 1'b0, run_clk = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic        pready, pslverr, err, src_clk, sync_out, sync_oe;
    logic        ready, ramp_done, ext_ref, pll_ck;
    logic [1:0]  del_lvl = 2'h0, ramp_lvl = 2'h0, cfg_lvl = 2'h0;
    logic [1:0]  sync_lvl = 2'h1;
    logic [4:0]  del_res = 5'h0, ramp_res = 5'h0, sync_res = 5'h3;
    logic [15:0] vref;
    wire logic   pin;
    int          n_mismatch = 0, n_compared = 0, seed = 32'hec6e;
    int          i, t, e_d, e_r, exp_q[$];
    // pin level from the dut enable alone: sync_out when sync_oe, else the source
    assign pin = sync_oe ? sync_out : src_clk;
    always #5 pclk = ~pclk;
    sssc_clk_src i_src (.run(run_clk), .clk_out(src_clk));
    sssc_top #(.CHECK_CYC(CK), .MS_CYC(MS)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .turn_on(turn_on),
        .delay_strap(del_lvl), .delay_select_resistor(del_res),
        .ramp_strap(ramp_lvl), .ramp_select_resistor(ramp_res),
        .cfg_strap(cfg_lvl), .sync_strap(sync_lvl),
        .sync_select_resistor(sync_res), .sync_in(pin),
        .sync_out(sync_out), .sync_oe(sync_oe), .ready(ready), .vref(vref),
        .ramp_done(ramp_done), .pll_ext_ref(ext_ref), .pll_clk(pll_ck));
    // model: time in ms from strap level and resistor step
    function automatic int exp_ms(input logic [1:0] l, input logic [4:0] r);
        case (l)
            2'h0: return 10;
            2'h1: return 50;
            2'h2: return 100;
            default: return int'(r) * 10;
        endcase
    endfunction
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_ready();
        t = 0;
        while (ready !== 1'b1 && t < CK + 20) begin
            @(negedge pclk);
            t++;
        end
        `CHK(ready, 1'b1)
        @(posedge pclk);
    endtask
    // restore: memory check again, access refused meanwhile
    task automatic restore();
        apb(1'b1, A_CTRL, 1);
        t = 0;
        while (ready === 1'b1 && t < 8) begin
            @(negedge pclk);
            t++;
        end
        @(posedge pclk);
        apb(1'b0, A_STATUS, 0);
        `CHK(err, 1'b1)
        wait_ready();
    endtask
    // turn on, time the pre-ramp wait and the ramp, then turn off
    task automatic run_on(input int d, input int r);
        int ts, td;
        ts = -1;
        td = -1;
        t = 0;
        turn_on <= 1'b1;
        while (td < 0 && t < 20000) begin
            @(negedge pclk);
            t++;
            if (ts < 0 && vref !== 16'h0) ts = t;
            if (ramp_done === 1'b1) td = t;
        end
        `CHK(ts >= (INIT + d) * MS, 1'b1)
        `CHK(ts <= (INIT + d) * MS + 4030, 1'b1)
        `CHK(td - ts >= (r - 1) * MS - 4, 1'b1)
        `CHK(td - ts <= r * MS + 4, 1'b1)
        `CHK(vref, VTGT_RST)
        @(posedge pclk);
        turn_on <= 1'b0;
        repeat (8) @(posedge pclk);
        `CHK(ramp_done, 1'b0)
    endtask
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, A_VTGT, 0);
        `CHK(err, 1'b1)
        wait_ready();
        apb(1'b0, A_VTGT, 0);
        `CHK(q, {16'h0, VTGT_RST})
        apb(1'b0, 8'h18, 0);
        `CHK({err, q}, {1'b1, 32'h0})
        $display("test reset and registers done");
        run_clk <= 1'b1;
        for (i = 0; i < 4; i++) begin
            del_lvl <= 2'(i);
            ramp_lvl <= 2'(3 - i);
            del_res <= 5'(($random(seed) & 32'h7fff) % 21);
            ramp_res <= 5'(($random(seed) & 32'h7fff) % 21);
            @(posedge pclk);
            e_d = exp_ms(del_lvl, del_res);
            e_r = exp_ms(ramp_lvl, ramp_res);
            restore();
            del_res <= 5'h14;
            ramp_res <= 5'h0;
            run_on(e_d, e_r);
            `CHK(ext_ref, 1'b1)
            $display("test strap run %0d done", i);
        end
        for (i = 0; i < 6; i++) begin
            e_d = (i < 2) ? (i == 0 ? 3 : 41) : ($random(seed) & 63);
            exp_q.push_back(e_d < 4 ? 4 : (e_d > 40 ? 40 : e_d));
            apb(1'b1, A_FREQ, e_d);
            apb(1'b0, A_FREQ, 0);
            `CHK(q, 32'(exp_q.pop_front()))
        end
        $display("test divider done");
        apb(1'b1, A_DELAY, 0);
        apb(1'b1, A_RAMP, 0);
        apb(1'b0, A_RAMP, 0);
        `CHK(q, 32'h0)
        run_on(0, 0);
        $display("test bus override done");
        cfg_lvl <= LVL_HIGH;
        run_clk <= 1'b0;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        wait_ready();
        @(negedge pclk);
        `CHK({sync_oe, ext_ref}, 2'b10)
        t = 0;
        e_d = pin;
        while (pin === 1'(e_d) && t < 400) begin
            @(negedge pclk);
            t++;
        end
        `CHK(t < 400, 1'b1)
        t = 0;
        e_d = pin;
        while (pin === 1'(e_d) && t < 400) begin
            @(negedge pclk);
            t++;
        end
        `CHK(t, int'(OSC_PRE) * int'(N_400K))
        `CHK(pll_ck, pin)
        $display("test output role done");
        wrap_up();
    end
    // watchdog against a hang
    initial begin
        #1_000_000;
        n_mismatch++;
        wrap_up();
    end
endmodule // sssc_top_bench
